/* include/interval_timer_defines.svh */
`ifndef INTERVAL_TIMER_DEFINES_SVH
`define INTERVAL_TIMER_DEFINES_SVH

`define CNT_W 16
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define CNT_TWO 16'h0002
`define CNT_FULL 17'h10000
`define MODE_W 3
`define MODE_RESET 3'h0
`define RL_W 2
`define RL_LSB 2'h1
`define RL_MSB 2'h2
`define RL_BOTH 2'h3
`define RL_RESET 2'h3

`endif

/* include/interval_timer_pkg.sv */
`include "interval_timer_defines.svh"
`default_nettype none
package interval_timer_pkg;
  typedef enum logic [2:0] {
    MODE_TERMINAL = 3'h0,
    MODE_ONE_SHOT = 3'h1,
    MODE_RATE = 3'h2,
    MODE_SQUARE = 3'h3,
    MODE_STROBE = 3'h4
  } mode_t;

  // Gray-coded along idle, load pending, counting
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN = 2'b11
  } phase_t;
endpackage
`default_nettype wire

/* verilog/interval_timer_counter.sv */
// Function
// - Mode 0: output low on control write, high when count element hits zero.
// - Mode 0: gate high counts, gate low suspends; gate never touches output.
// - Mode 0: count loads on next tick undecremented; output rises after N+1 ticks.
// - Mode 0 two-byte: first byte halts count, forces low; second loads next tick.
// - Mode 0: count written with gate low still loads; N ticks after gate rises.
// - Mode 1: output high after control; trigger loads, output low N ticks, once.
// - Mode 1: gate fall ignored; gate rise retriggers, reloading holding register.
// - Mode 1: new count leaves the running pulse alone until next retrigger.
// - Mode 2: output high; at count one low for one tick, reload, period N.
// - Mode 2: gate low stops count, forces output high; rise reloads next tick.
// - Mode 2: initial count loads next tick; first low pulse N ticks after write.
// - Mode 2: rewrite keeps period; trigger loads next tick, else at period end.
// - Mode 3: gate low stops count, forces high; reload on tick after gate rise.
// - Mode 3: rewrite keeps half cycle; trigger loads next tick, else at half end.
// - Mode 3 even: load, minus two per tick; at two toggle and reload.
// - Mode 3 odd: load N-1, minus two; zero drives low, two drives high, reload.
// - Mode 4: output high; write starts; at zero one-tick low strobe.
// - Mode 4: gate high counts, gate low inhibits; gate never touches output.
// - Mode 4: count loads next tick undecremented; strobe after N+1 ticks.
// - Mode 4 two-byte: first byte harmless; second loads next tick, retriggers.
`include "interval_timer_defines.svh"
`default_nettype none
module interval_timer_counter (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cnt_clk_i,
  input wire logic gate_i,
  input wire logic ctrl_wr_i,
  input wire logic [`MODE_W-1:0] ctrl_mode_i,
  input wire logic [`RL_W-1:0] ctrl_rl_i,
  input wire logic data_wr_i,
  input wire logic [7:0] data_i,
  output logic out_o,
  output logic null_count_o,
  output logic [`CNT_W-1:0] count_o
);

  typedef struct packed {
    logic [1:0] clk_sync;
    logic [1:0] gate_sync;
    logic clk_prev;
    logic gate_prev;
    logic trig;
    interval_timer_pkg::mode_t mode;
    logic [`RL_W-1:0] rl;
    logic msb_next;
    logic [7:0] lsb_hold;
    logic [`CNT_W-1:0] holding;
    logic [`CNT_W-1:0] element;
    interval_timer_pkg::phase_t phase;
    logic new_count;
    logic out;
    logic null_count;
  } state_t;

  state_t q, d;

  // Counts of zero stand for 10000h
  function automatic logic [16:0] full_count(input logic [`CNT_W-1:0] v);
    full_count = (v == `CNT_ZERO) ? `CNT_FULL : {1'b0, v};
  endfunction

  // Square wave reload value: odd counts drop to N-1
  function automatic logic [`CNT_W-1:0] sq_load(input logic [`CNT_W-1:0] v);
    sq_load = {v[`CNT_W-1:1], 1'b0};
  endfunction

  // Periodic modes park the counter while the gate is low
  function automatic logic is_periodic(input interval_timer_pkg::mode_t m);
    is_periodic = (m == interval_timer_pkg::MODE_RATE) ||
                  (m == interval_timer_pkg::MODE_SQUARE);
  endfunction

  // Down step; wraps through zero as a full count
  function automatic logic [`CNT_W-1:0] count_down(input logic [`CNT_W-1:0] v,
                                                  input logic [`CNT_W-1:0] step);
    count_down = v - step;
  endfunction

  logic tick;
  logic gate_s;
  logic gate_rise;
  logic [`CNT_W-1:0] wr_value;
  logic wr_done;
  logic wr_first;

  always_comb begin
    // Only the second synchroniser stage feeds logic
    tick = q.clk_prev & ~q.clk_sync[1];
    gate_s = q.gate_sync[1];
    gate_rise = gate_s & ~q.gate_prev;
    wr_done = 1'b0;
    wr_first = 1'b0;
    wr_value = q.holding;
    if (data_wr_i) begin
      case (q.rl)
        `RL_LSB: begin
          wr_done = 1'b1;
          wr_value = {8'h00, data_i};
        end
        `RL_MSB: begin
          wr_done = 1'b1;
          wr_value = {data_i, 8'h00};
        end
        default: begin
          if (q.msb_next) begin
            wr_done = 1'b1;
            wr_value = {data_i, q.lsb_hold};
          end else begin
            wr_first = 1'b1;
          end
        end
      endcase
    end
  end

  logic [16:0] elem_full;
  logic load_now;
  logic [`CNT_W-1:0] load_val;

  always_comb begin
    d = q;
    elem_full = full_count(q.element);
    load_now = 1'b0;
    load_val = q.holding;
    d.clk_sync = {q.clk_sync[0], cnt_clk_i};
    d.gate_sync = {q.gate_sync[0], gate_i};
    d.clk_prev = q.clk_sync[1];
    d.gate_prev = gate_s;

    // Control word clears the element and any pending trigger
    if (ctrl_wr_i) begin
      d.mode = interval_timer_pkg::mode_t'(ctrl_mode_i);
      d.rl = ctrl_rl_i;
      d.msb_next = 1'b0;
      d.element = `CNT_ZERO;
      d.phase = interval_timer_pkg::ST_IDLE;
      d.new_count = 1'b0;
      d.null_count = 1'b1;
      d.trig = 1'b0;
      d.out = (ctrl_mode_i != `MODE_RESET);
    end else begin
      if (wr_first) begin
        d.lsb_hold = data_i;
        d.msb_next = 1'b1;
        if (q.mode == interval_timer_pkg::MODE_TERMINAL) begin
          d.phase = interval_timer_pkg::ST_IDLE;
          d.out = 1'b0;
        end
      end
      if (wr_done) begin
        d.msb_next = 1'b0;
        d.holding = wr_value;
        d.null_count = 1'b1;
        case (q.mode)
          interval_timer_pkg::MODE_TERMINAL: begin
            d.phase = interval_timer_pkg::ST_LOAD;
            d.out = 1'b0;
          end
          interval_timer_pkg::MODE_STROBE: begin
            d.phase = interval_timer_pkg::ST_LOAD;
          end
          interval_timer_pkg::MODE_ONE_SHOT: begin
            d.new_count = 1'b1;
          end
          default: begin
            // First count loads on the next tick; later ones wait for period end
            if (q.phase == interval_timer_pkg::ST_IDLE) begin
              d.phase = interval_timer_pkg::ST_LOAD;
            end else begin
              d.new_count = 1'b1;
            end
          end
        endcase
      end

      // Gate low forces output high at once in periodic modes
      if (is_periodic(q.mode) && !gate_s) begin
        d.out = 1'b1;
        if (q.phase == interval_timer_pkg::ST_RUN) begin
          d.phase = interval_timer_pkg::ST_LOAD;
        end
      end

      // A write in the same cycle swallows the tick
      if (tick && !wr_done && !wr_first) begin
        case (q.mode)
          interval_timer_pkg::MODE_TERMINAL,
          interval_timer_pkg::MODE_STROBE: begin
            if (q.phase == interval_timer_pkg::ST_LOAD) begin
              load_now = 1'b1;
              d.phase = interval_timer_pkg::ST_RUN;
            end else if (q.phase == interval_timer_pkg::ST_RUN && gate_s) begin
              d.element = count_down(q.element, `CNT_ONE);
              if (q.element == `CNT_ONE) begin
                if (q.mode == interval_timer_pkg::MODE_TERMINAL) begin
                  d.out = 1'b1;
                  d.phase = interval_timer_pkg::ST_IDLE;
                end else begin
                  d.out = 1'b0;
                end
              end else if (q.mode == interval_timer_pkg::MODE_STROBE) begin
                d.out = 1'b1;
                if (!q.out) begin
                  d.phase = interval_timer_pkg::ST_IDLE;
                end
              end
            end else if (q.mode == interval_timer_pkg::MODE_STROBE) begin
              d.out = 1'b1;
            end
          end
          interval_timer_pkg::MODE_ONE_SHOT: begin
            if (q.trig) begin
              d.trig = 1'b0;
              d.new_count = 1'b0;
              load_now = 1'b1;
              d.out = 1'b0;
              d.phase = interval_timer_pkg::ST_RUN;
            end else if (q.phase == interval_timer_pkg::ST_RUN) begin
              d.element = count_down(q.element, `CNT_ONE);
              if (q.element == `CNT_ONE) begin
                d.out = 1'b1;
                d.phase = interval_timer_pkg::ST_IDLE;
              end
            end
          end
          interval_timer_pkg::MODE_RATE: begin
            if (q.phase == interval_timer_pkg::ST_LOAD && gate_s) begin
              load_now = 1'b1;
              d.trig = 1'b0;
              d.new_count = 1'b0;
              d.phase = interval_timer_pkg::ST_RUN;
            end else if (q.phase == interval_timer_pkg::ST_RUN && gate_s) begin
              if (q.trig && q.new_count) begin
                load_now = 1'b1;
                d.trig = 1'b0;
                d.new_count = 1'b0;
                d.out = 1'b1;
              end else if (q.element == `CNT_TWO) begin
                d.element = `CNT_ONE;
                d.out = 1'b0;
              end else if (q.element == `CNT_ONE) begin
                load_now = 1'b1;
                d.new_count = 1'b0;
                d.out = 1'b1;
              end else begin
                d.element = count_down(q.element, `CNT_ONE);
              end
            end
          end
          interval_timer_pkg::MODE_SQUARE: begin
            if (q.phase == interval_timer_pkg::ST_LOAD && gate_s) begin
              load_now = 1'b1;
              load_val = sq_load(q.holding);
              d.trig = 1'b0;
              d.new_count = 1'b0;
              d.out = 1'b1;
              d.phase = interval_timer_pkg::ST_RUN;
            end else if (q.phase == interval_timer_pkg::ST_RUN && gate_s) begin
              if (q.trig && q.new_count) begin
                load_now = 1'b1;
                load_val = sq_load(q.holding);
                d.trig = 1'b0;
                d.new_count = 1'b0;
              end else if (q.element == `CNT_TWO && (!q.holding[0] || !q.out)) begin
                load_now = 1'b1;
                load_val = sq_load(q.holding);
                d.new_count = 1'b0;
                d.out = ~q.out;
              end else if (elem_full == `CNT_FULL && q.holding[0] && q.out) begin
                load_now = 1'b1;
                load_val = sq_load(q.holding);
                d.new_count = 1'b0;
                d.out = 1'b0;
              end else begin
                d.element = count_down(q.element, `CNT_TWO);
              end
            end
          end
          default: begin
            d.phase = interval_timer_pkg::ST_IDLE;
          end
        endcase
        if (load_now) begin
          d.element = load_val;
          d.null_count = 1'b0;
        end
      end
      // A trigger in the same cycle as its clear still counts
      if (gate_rise) begin
        d.trig = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.rl <= `RL_RESET;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_o <= 1'b0;
    end else begin
      out_o <= d.out;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      null_count_o <= 1'b0;
    end else begin
      null_count_o <= d.null_count;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= `CNT_ZERO;
    end else begin
      count_o <= d.element;
    end
  end

endmodule
`default_nettype wire

/* bench/interval_timer_counter_properties.sv */
`include "interval_timer_defines.svh"
`default_nettype none
module interval_timer_counter_properties (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cnt_clk_i,
  input wire logic gate_i,
  input wire logic ctrl_wr_i,
  input wire logic [`MODE_W-1:0] ctrl_mode_i,
  input wire logic [`RL_W-1:0] ctrl_rl_i,
  input wire logic data_wr_i,
  input wire logic [7:0] data_i,
  input wire logic out_o,
  input wire logic null_count_o,
  input wire logic [`CNT_W-1:0] count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`MODE_W-1:0] mode_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= `MODE_RESET;
    end else if (ctrl_wr_i) begin
      mode_q <= ctrl_mode_i;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Gate low long enough to pass the synchroniser
  sequence gate_low_run;
    ((mode_q == 3'h2 || mode_q == 3'h3) && !gate_i)[*5];
  endsequence
  chk_ctrl_low: assert property (ctrl_wr_i && ctrl_mode_i == 3'h0 |-> ##[1:2] !out_o)
    else $error("mode 0 setup not low");
  chk_ctrl_high: assert property (ctrl_wr_i && ctrl_mode_i inside {[3'h1:3'h4]} |-> ##[1:2] out_o)
    else $error("setup not high");
  chk_zero_rise: assert property (mode_q == 3'h0 && $rose(out_o) |-> count_o == `CNT_ZERO)
    else $error("mode 0 rise off zero");
  chk_strobe_zero: assert property (mode_q == 3'h4 && $fell(out_o) |-> count_o == `CNT_ZERO)
    else $error("strobe off zero");
  chk_rate_low: assert property (mode_q == 3'h2 && $fell(out_o) |-> count_o == `CNT_ONE)
    else $error("rate pulse off one");
  chk_gate_high: assert property (gate_low_run |-> out_o)
    else $error("gate low left out low");
  chk_square_even: assert property (mode_q == 3'h3 && $changed(count_o) |-> !count_o[0])
    else $error("square count odd");
  chk_shot_load: assert property (mode_q == 3'h1 && $fell(out_o) |-> !null_count_o)
    else $error("one-shot without load");
endmodule
bind interval_timer_counter interval_timer_counter_properties i_checker (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cnt_clk_i(cnt_clk_i), .gate_i(gate_i), .ctrl_wr_i(ctrl_wr_i),
  .ctrl_mode_i(ctrl_mode_i), .ctrl_rl_i(ctrl_rl_i), .data_wr_i(data_wr_i), .data_i(data_i),
  .out_o(out_o), .null_count_o(null_count_o), .count_o(count_o));
`default_nettype wire

/* bench/timer_host_model.sv */
`default_nettype none
module timer_host_model (
  input wire logic clk_i,
  output logic ctrl_wr_o,
  output logic [2:0] ctrl_mode_o,
  output logic [1:0] ctrl_rl_o,
  output logic data_wr_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ctrl_wr_o = 1'h0;
    ctrl_mode_o = 3'h0;
    ctrl_rl_o = 2'h3;
    data_wr_o = 1'h0;
    data_o = 8'h00;
  end
  task automatic wr_ctrl(input logic [2:0] m, input logic [1:0] r);
    @(posedge clk_i);
    ctrl_wr_o <= 1'h1;
    ctrl_mode_o <= m;
    ctrl_rl_o <= r;
    @(posedge clk_i);
    ctrl_wr_o <= 1'h0;
  endtask
  task automatic wr_byte(input logic [7:0] b);
    @(posedge clk_i);
    data_wr_o <= 1'h1;
    data_o <= (ctrl_mode_o == 3'h2 && b == 8'h01) ? 8'h02 : b;
    @(posedge clk_i);
    data_wr_o <= 1'h0;
    data_o <= ~data_o;
  endtask
endmodule
`default_nettype wire

/* bench/interval_timer_counter_tb_top.sv */
`default_nettype none
module interval_timer_counter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, cc, gate, cw, dw, out, nul;
  logic [2:0] md;
  logic [1:0] rl;
  logic [7:0] dat;
  logic [15:0] cnt;
  int n_mismatch, checks_done;
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  timer_host_model i_timer_host_model (.clk_i(clk), .ctrl_wr_o(cw), .ctrl_mode_o(md),
    .ctrl_rl_o(rl), .data_wr_o(dw), .data_o(dat));
  interval_timer_counter i_interval_timer_counter (.clk_i(clk), .rst_n_i(rst_n), .cnt_clk_i(cc),
    .gate_i(gate), .ctrl_wr_i(cw), .ctrl_mode_i(md), .ctrl_rl_i(rl), .data_wr_i(dw),
    .data_i(dat), .out_o(out), .null_count_o(nul), .count_o(cnt));
  task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) begin
      cc <= 1'h0;
      repeat (5) @(posedge clk);
      cc <= 1'h1;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic g(input logic v);
    gate <= v;
    repeat (5) @(posedge clk);
  endtask
  task automatic wb(input logic [7:0] b);
    i_timer_host_model.wr_byte(b);
    repeat (2) @(posedge clk);
  endtask
  task automatic cwb(input logic [2:0] m, input logic [1:0] r, input logic [7:0] b);
    i_timer_host_model.wr_ctrl(m, r);
    wb(b);
  endtask
  task automatic t0;
    g(1'h0);
    cwb(3'h0, 2'h3, 8'h03);
    wb(8'h00);
    chk("m0 out", out, 1'h0);
    tk(3);
    chk("m0 held", cnt, 16'h0003);
    g(1'h1);
    tk(2);
    chk("m0 early", out, 1'h0);
    tk(1);
    chk("m0 end", out, 1'h1);
    wb(8'h02);
    chk("m0 byte1", out, 1'h0);
    wb(8'h00);
    tk(2);
    chk("m0 wait", out, 1'h0);
    tk(1);
    chk("m0 rise", out, 1'h1);
    cwb(3'h0, 2'h2, 8'h01);
    tk(1);
    chk("m0 msb", cnt, 16'h0100);
    $display("mode 0 done");
  endtask
  task automatic t1;
    cwb(3'h1, 2'h1, 8'h02);
    chk("m1 null", nul, 1'h1);
    tk(1);
    chk("m1 idle", out, 1'h1);
    g(1'h0);
    g(1'h1);
    tk(1);
    chk("m1 fire", out, 1'h0);
    chk("m1 loaded", nul, 1'h0);
    wb(8'h05);
    tk(1);
    chk("m1 keep", cnt, 16'h0001);
    tk(2);
    chk("m1 once", out, 1'h1);
    g(1'h0);
    g(1'h1);
    tk(1);
    chk("m1 retrig", cnt, 16'h0005);
    $display("mode 1 done");
  endtask
  task automatic t2;
    cwb(3'h2, 2'h1, 8'h03);
    chk("m2 start", out, 1'h1);
    tk(3);
    chk("m2 low", out, 1'h0);
    g(1'h0);
    chk("m2 gate", out, 1'h1);
    g(1'h1);
    tk(1);
    chk("m2 reload", cnt, 16'h0003);
    wb(8'h04);
    tk(2);
    chk("m2 period", out, 1'h0);
    tk(1);
    chk("m2 new", cnt, 16'h0004);
    $display("mode 2 done");
  endtask
  task automatic t3(input logic [7:0] n, input int ticks, input int ones);
    int hi;
    hi = 0;
    cwb(3'h3, 2'h1, n);
    tk(1);
    chk("m3 load", cnt, {n[7:1], 1'h0});
    repeat (ticks) begin
      tk(1);
      hi += out;
    end
    chk("m3 high ticks", hi, ones);
    $display("mode 3 done");
  endtask
  task automatic t4;
    cwb(3'h4, 2'h1, 8'h02);
    chk("m4 start", out, 1'h1);
    g(1'h0);
    tk(2);
    chk("m4 inhibit", cnt, 16'h0002);
    g(1'h1);
    tk(1);
    chk("m4 wait", out, 1'h1);
    tk(1);
    chk("m4 strobe", out, 1'h0);
    tk(1);
    chk("m4 back", out, 1'h1);
    cwb(3'h4, 2'h3, 8'h02);
    chk("m4 byte1", out, 1'h1);
    wb(8'h00);
    tk(2);
    chk("m4 re wait", out, 1'h1);
    tk(1);
    chk("m4 re strobe", out, 1'h0);
    $display("mode 4 done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'h0;
    cc = 1'h1;
    gate = 1'h1;
    n_mismatch = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t0();
    t1();
    t2();
    t3(8'h04, 8, 4);
    t3(8'h05, 10, 6);
    t4();
    test_done();
  end
  initial begin
    #40000;
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire
